//--- shared/port_power_pkg.sv
/*
  Shared constants, register map and types for the port power switch
  control block. Assumes a 25 MHz core clock and a 32-bit APB bus.
*/
package port_power_pkg;

  localparam int unsigned PORT_COUNT = 5;
  localparam int unsigned CLOCK_HZ = 25000000;

  // Register byte offsets
  localparam logic [11:0] CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] EVENT_OFFSET = 12'h008;
  localparam logic [11:0] EVENT_CLEAR_OFFSET = 12'h00C;
  localparam logic [11:0] EVENT_ENABLE_OFFSET = 12'h010;

  // Control fields: port power request bits
  localparam int unsigned CONTROL_POWER_LSB = 0;
  // Status fields
  localparam int unsigned STATUS_FAULT_LSB = 0;
  localparam int unsigned STATUS_ENABLED_LSB = 8;
  localparam int unsigned STATUS_GANGED_BIT = 16;
  localparam int unsigned STATUS_BUS_POWERED_BIT = 17;

  // Reset values
  localparam logic [PORT_COUNT-1:0] CONTROL_RESET = 5'h00;
  localparam logic [PORT_COUNT-1:0] EVENT_RESET = 5'h00;
  localparam logic [PORT_COUNT-1:0] EVENT_ENABLE_RESET = 5'h00;

  // Reset pulse figures for the system side
  localparam int unsigned RESET_MIN_NS = 250;
  localparam int unsigned RESET_MAX_MS = 5;
  localparam longint unsigned RESET_MIN_CYCLES =
    (longint'(RESET_MIN_NS) * CLOCK_HZ + 64'd999999999) / 64'd1000000000;
  localparam longint unsigned RESET_MAX_CYCLES =
    longint'(RESET_MAX_MS) * CLOCK_HZ / 64'd1000;

  typedef struct packed {
    logic [PORT_COUNT-1:0] out;
    logic [PORT_COUNT-1:0] oe;
  } power_pins_s;

endpackage : port_power_pkg

//--- verilog/input_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous level inputs.
  Assumes the inputs are quasi-static levels; no event is carried.
*/
`timescale 1ns/1ps
module input_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage;
  logic [WIDTH-1:0] next_stage;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage = async_i;
    next_sync = stage;
  end

  // First stage read only by the second
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stage <= RESET_VALUE;
      sync_o <= RESET_VALUE;
    end else begin
      stage <= next_stage;
      sync_o <= next_sync;
    end
  end

endmodule : input_sync

//--- verilog/port_power_switch_control.sv
/*
  Downstream port power switching with over-current handling, APB slave
  for control, status and fault events. Assumes external open-drain pull-ups
  on the power-enable lines and static strap inputs.
*/
`timescale 1ns/1ps
module port_power_switch_control
  import port_power_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Straps and fault pins
  input wire logic ganged_i,
  input wire logic bus_powered_select_n_i,
  input wire logic [PORT_COUNT-1:0] port_overcurrent_n_i,
  // Power switch pins, open drain
  input wire logic [PORT_COUNT-1:0] port_power_enable_n_i,
  output logic [PORT_COUNT-1:0] port_power_enable_n_o,
  output logic [PORT_COUNT-1:0] port_power_enable_n_oe_o,
  // Interrupt
  output logic irq_o
);

  logic [PORT_COUNT-1:0] fault_n_sync;
  logic [1:0] strap_sync;
  logic ganged;
  logic bus_powered;
  logic [PORT_COUNT-1:0] fault;
  logic [PORT_COUNT-1:0] fault_prev;
  logic [PORT_COUNT-1:0] next_fault_prev;
  logic [PORT_COUNT-1:0] power_req;
  logic [PORT_COUNT-1:0] next_power_req;
  logic [PORT_COUNT-1:0] event_flags;
  logic [PORT_COUNT-1:0] next_event_flags;
  logic [PORT_COUNT-1:0] event_enable;
  logic [PORT_COUNT-1:0] next_event_enable;
  logic [PORT_COUNT-1:0] enable_on;
  logic [PORT_COUNT-1:0] next_enable_on;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic access;
  logic setup;
  logic wr;
  logic clear_strobe;
  logic addr_ok;
  power_pins_s pins;

  // Pin readback unused: enables are output only here
  logic unused_pin;
  assign unused_pin = ^port_power_enable_n_i;

  // Fault inputs idle high, so reset the synchroniser high
  input_sync #(
    .WIDTH(PORT_COUNT),
    .RESET_VALUE({PORT_COUNT{1'b1}})
  ) fault_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(port_overcurrent_n_i),
    .sync_o(fault_n_sync)
  );

  input_sync #(
    .WIDTH(2),
    .RESET_VALUE(2'h3)
  ) strap_sync_inst (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({ganged_i, bus_powered_select_n_i}),
    .sync_o(strap_sync)
  );

  assign ganged = strap_sync[1];
  assign bus_powered = ~strap_sync[0];

  // Shared fault in ganged mode, per-port otherwise
  always_comb begin
    if (ganged) begin
      fault = {PORT_COUNT{|(~fault_n_sync)}};
    end else begin
      fault = ~fault_n_sync;
    end
  end

  assign access = psel_i & penable_i;
  assign setup = psel_i & ~penable_i;
  assign wr = access & pwrite_i;
  assign clear_strobe = wr & (paddr_i == EVENT_CLEAR_OFFSET);
  assign addr_ok = (paddr_i == CONTROL_OFFSET) |
                   (paddr_i == STATUS_OFFSET) |
                   (paddr_i == EVENT_OFFSET) |
                   (paddr_i == EVENT_CLEAR_OFFSET) |
                   (paddr_i == EVENT_ENABLE_OFFSET);

  // Register file and fault events
  always_comb begin
    next_power_req = power_req;
    next_event_enable = event_enable;
    next_fault_prev = fault;
    next_event_flags = event_flags;
    if (wr && paddr_i == CONTROL_OFFSET) begin
      next_power_req = pwdata_i[CONTROL_POWER_LSB +: PORT_COUNT];
    end
    if (wr && paddr_i == EVENT_ENABLE_OFFSET) begin
      next_event_enable = pwdata_i[PORT_COUNT-1:0];
    end
    if (clear_strobe) begin
      next_event_flags = event_flags & ~pwdata_i[PORT_COUNT-1:0];
    end
    // Set beats clear so a fault in the clear cycle is kept
    next_event_flags = next_event_flags | (fault & ~fault_prev);
    // Latched shutdown until software re-requests power
    next_power_req = next_power_req & ~fault;
    next_prdata = 32'h0000_0000;
    // Latched at setup so the error stands while pready is sampled
    next_pslverr = setup & ~addr_ok;
    case (paddr_i)
      CONTROL_OFFSET: next_prdata[PORT_COUNT-1:0] = power_req;
      STATUS_OFFSET: begin
        next_prdata[STATUS_FAULT_LSB +: PORT_COUNT] = fault;
        next_prdata[STATUS_ENABLED_LSB +: PORT_COUNT] = enable_on;
        next_prdata[STATUS_GANGED_BIT] = ganged;
        next_prdata[STATUS_BUS_POWERED_BIT] = bus_powered;
      end
      EVENT_OFFSET: next_prdata[PORT_COUNT-1:0] = event_flags;
      EVENT_ENABLE_OFFSET: next_prdata[PORT_COUNT-1:0] = event_enable;
      default: next_prdata = 32'h0000_0000;
    endcase
    // Read data latched at setup, standing through the access phase
    if (!(setup && !pwrite_i)) begin
      next_prdata = prdata_o;
    end
  end

  // Switch drive from request, gang strap and faults
  always_comb begin
    if (ganged) begin
      next_enable_on = {PORT_COUNT{power_req[0]}} & ~fault;
    end else begin
      next_enable_on = power_req & ~fault;
    end
    // Bus-powered hub still switches; select only reported here
    next_enable_on = next_enable_on & {PORT_COUNT{1'b1}};
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      power_req <= CONTROL_RESET;
      event_flags <= EVENT_RESET;
      event_enable <= EVENT_ENABLE_RESET;
      fault_prev <= {PORT_COUNT{1'b0}};
      enable_on <= {PORT_COUNT{1'b0}};
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      power_req <= next_power_req;
      event_flags <= next_event_flags;
      event_enable <= next_event_enable;
      fault_prev <= next_fault_prev;
      enable_on <= next_enable_on;
      prdata_o <= next_prdata;
      pslverr_o <= next_pslverr;
    end
  end

  // Open drain: only ever drives low
  generate
    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_pin
      assign pins.out[p] = 1'b0;
      assign pins.oe[p] = enable_on[p];
    end
  endgenerate

  assign port_power_enable_n_o = pins.out;
  assign port_power_enable_n_oe_o = pins.oe;
  assign pready_o = 1'b1;
  assign irq_o = |(event_flags & event_enable);

endmodule : port_power_switch_control

//--- testbench/ppsc_checker.sv
/* Assertions for port power switch control, bound to its top.
   Assumes straps change only in reset and zero-wait APB answers. */
`timescale 1ns/1ps
module ppsc_checker
  import port_power_pkg::*;
(
  // Clock, reset, APB
  input wire logic clock_i, rst_i, psel_i, penable_i, pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i, prdata_o,
  input wire logic pready_o, pslverr_o,
  // Straps and pins
  input wire logic ganged_i, bus_powered_select_n_i,
  input wire logic [4:0] port_overcurrent_n_i,
  input wire logic [4:0] port_power_enable_n_o, port_power_enable_n_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire logic [4:0] ovc = port_overcurrent_n_i;
  wire logic [4:0] oe = port_power_enable_n_oe_o;
  logic [4:0] h1, h2, h3, h4;
  // Fault history; a sampled low reaches the synchroniser output two cycles later
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) {h1, h2, h3, h4} <= '1;
    else {h1, h2, h3, h4} <= {ovc, h1, h2, h3};
  end
  wire logic [4:0] hist = ovc | h1 | h2 | h3 | h4;
  sequence s_wr;
    psel_i && penable_i && pwrite_i && paddr_i == CONTROL_OFFSET;
  endsequence
  sequence s_calm;
    (!ganged_i && ovc == 5'h1F)[*4];
  endsequence
  property p_od; port_power_enable_n_o == 5'h00; endproperty
  a_od: assert property (p_od)
    else $error("enable pin driven high");
  property p_port; s_calm ##0 s_wr |=> ##1 oe == $past(pwdata_i[4:0], 2);
  endproperty
  a_port: assert property (p_port)
    else $error("port enables differ from request");
  property p_gang; (ganged_i && ovc == 5'h1F)[*4] ##0 s_wr
    |=> ##1 oe == {5{$past(pwdata_i[0], 2)}}; endproperty
  a_gang: assert property (p_gang)
    else $error("ganged enables not switched together");
  property p_fport; !ganged_i[*5] |-> (oe & ~hist) == 5'h00; endproperty
  a_fport: assert property (p_fport)
    else $error("faulted port still powered");
  property p_fgang; ganged_i[*5] ##0 hist != 5'h1F |-> oe == 5'h00;
  endproperty
  a_fgang: assert property (p_fgang)
    else $error("ganged fault left a port powered");
  property p_stat; psel_i && penable_i && !pwrite_i &&
    paddr_i == STATUS_OFFSET |->
    prdata_o[17:16] == {!bus_powered_select_n_i, ganged_i}; endproperty
  a_stat: assert property (p_stat)
    else $error("strap status wrong");
  property p_err; psel_i && penable_i && paddr_i > EVENT_ENABLE_OFFSET
    |-> pslverr_o; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped");
  property p_rdy; psel_i |-> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
endmodule : ppsc_checker

bind port_power_switch_control ppsc_checker chk_i (.*);

//--- testbench/power_switch_model.sv
/* External power switches with over-current flags, one per port.
   Assumes enable lines already resolved with their pull-ups. */
`timescale 1ns/1ps
module power_switch_model (
  // Clock
  input wire logic clock_i,
  // Enable lines and commanded overloads
  input wire logic [4:0] pin_n_i,
  input wire logic [4:0] overload_i,
  // Flags, high when healthy
  output logic [4:0] overcurrent_n_o
);
  // Conducts while its line is low; flag latches while overloaded
  always_ff @(posedge clock_i) begin
    overcurrent_n_o <= ~(overload_i & (~pin_n_i | ~overcurrent_n_o));
  end
endmodule : power_switch_model

//--- testbench/tb.sv
/* Bench for port power switch control: APB master and switch model.
   Assumes zero-wait APB slave and straps changed only in reset. */
`timescale 1ns/1ps
module tb;
  import port_power_pkg::*;
  logic clock_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic ganged_i, bus_powered_select_n_i, irq_o, er;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [4:0] port_overcurrent_n_i, port_power_enable_n_i, ovl;
  logic [4:0] port_power_enable_n_o, port_power_enable_n_oe_o;
  int n_errors = 0, n_checks = 0, cyc = 0;
  // Pull-up wins unless the design drives the line
  assign port_power_enable_n_i =
    ~port_power_enable_n_oe_o | port_power_enable_n_o;
  port_power_switch_control uut (.*);
  power_switch_model sw (.clock_i(clock_i),
    .pin_n_i(port_power_enable_n_i), .overload_i(ovl),
    .overcurrent_n_o(port_overcurrent_n_i));
  initial begin
    clock_i = 0;
    forever #20 clock_i = ~clock_i;
  end
  task wrap_up;
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    // Taken at the ready edge, before the edge's own updates land
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  // Straps move only inside reset; 7 cycles clears the minimum pulse
  task reset(input logic g, input logic b);
    rst_i <= 1; ganged_i <= g; bus_powered_select_n_i <= b;
    tick(7);
    rst_i <= 0;
  endtask : reset
  task t_port;
    reset(0, 0);
    chk(port_power_enable_n_oe_o, 5'h00, "oe at reset");
    apb(1, CONTROL_OFFSET, 32'h15);
    tick(2);
    chk({~port_power_enable_n_i}, 5'h15, "power");
    apb(0, STATUS_OFFSET, 0);
    chk(rd[17:8], 10'h215, "status");
    apb(1, EVENT_ENABLE_OFFSET, 32'h1F);
    ovl <= 5'h04;
    tick(8);
    chk({~port_power_enable_n_i}, 5'h11, "fault off");
    chk(irq_o, 1, "irq");
    ovl <= 0;
    apb(0, EVENT_OFFSET, 0);
    chk(rd, 4, "event");
    apb(1, EVENT_CLEAR_OFFSET, 4);
    tick(2);
    chk(irq_o, 0, "irq clear");
    apb(1, EVENT_ENABLE_OFFSET, 0);
    ovl <= 5'h01;
    tick(8);
    chk({~port_power_enable_n_i}, 5'h10, "fault 0");
    chk(irq_o, 0, "irq masked");
    ovl <= 0;
    apb(0, 12'h020, 0);
    chk(er, 1, "unmapped error");
    chk(rd, 0, "unmapped data");
  endtask : t_port
  task t_gang;
    reset(1, 1);
    apb(1, CONTROL_OFFSET, 1);
    tick(2);
    chk({~port_power_enable_n_i}, 5'h1F, "gang on");
    apb(0, STATUS_OFFSET, 0);
    chk(rd[17:16], 2'b01, "gang status");
    ovl <= 5'h10;
    tick(8);
    chk({~port_power_enable_n_i}, 5'h00, "gang fault");
    ovl <= 0;
  endtask : t_gang
  initial begin
    rst_i = 1; ganged_i = 0; bus_powered_select_n_i = 0; ovl = 0;
    psel_i = 0; penable_i = 0; pwrite_i = 0; paddr_i = 0; pwdata_i = 0;
    t_port;
    t_gang;
    wrap_up;
  end
endmodule : tb
